// ### core/eac_pkg.sv
// Constants, register map and carrier types of the EEPROM access controller.
// Assumes one 25 MHz clock and an APB register bus with 32-bit data.
package eac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] OFS_ADDR = 12'h000;
    localparam logic [11:0] OFS_DATA = 12'h004;
    localparam logic [11:0] OFS_CTRL = 12'h008;
    localparam logic [11:0] OFS_STAT = 12'h00C;
    localparam logic [11:0] OFS_MASK = 12'h010;

    // Reset values
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [7:0]  DATA_RESET = 8'h00;
    localparam logic        RIE_RESET  = 1'b0;
    localparam logic [2:0]  MASK_RESET = 3'h0;

    // Address field width of the largest variant
    localparam int ADDR_BITS = 12;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int ARM_WINDOW       = 4;
    localparam int WRITE_STALL      = 2;
    localparam int READ_STALL       = 4;
    localparam int WRITE_OSC_CYCLES = 67584;
    localparam int WRITE_TIME_NS    = 8500000;
    localparam int CLK_PERIOD_NS    = 40;
    localparam int WRITE_CLKS       = WRITE_TIME_NS / CLK_PERIOD_NS;
    // Clock cycles per calibrated oscillator cycle, rounded down
    localparam int OSC_DIV_DEFAULT  = WRITE_CLKS / WRITE_OSC_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [3:0] reserved;
        logic       readyIrqEnable;
        logic       masterWriteArm;
        logic       writeStrobe;
        logic       readStrobe;
    } eac_ctrl_type;

    // Interrupt status and mask layout
    typedef struct packed {
        logic strobeRefused;
        logic readDone;
        logic writeDone;
    } eac_irq_type;

endpackage : eac_pkg

// ### core/eac_nv_mem.sv
// Byte-wide nonvolatile array model: synchronous write, registered read.
// A read in the cycle of a write to the same cell returns the old byte.
`timescale 1ns/1ns
module eac_nv_mem
    import eac_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS,
    parameter int DATA_W = 8
)
(
    // Clock
    input  wire logic              ref_clk,
    // Write side
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    // Read side
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData
);

    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    always_ff @(posedge ref_clk)
    begin
        if (wrEn)
        begin
            cells[wrAddr] <= wrData;
        end
        if (rdEn)
        begin
            rdData <= cells[rdAddr];
        end
    end

endmodule : eac_nv_mem

// ### core/eac_controller.sv
// EEPROM access controller: address, data and control registers on APB,
// armed write with timed duration, stalled read, ready and event interrupts.
// Assumes a CPU-side APB master on ref_clk and a flash busy level on ref_clk.
//
// Contract
// - Address bits 15..12 and control bits 7..4 always read zero.
// - Bytes addressed linearly by 12 bits; unused top bits only stored.
// - Data register sources write data and receives read data.
// - Ready interrupt held while strobe clear, enable and global enable set.
// - Write strobe starts a write only within four cycles of arming.
// - Arm bit clears itself four cycles after software sets it.
// - No write starts while flash self-programming is busy.
// - Write strobe clears itself when the write time has elapsed.
// - Starting a write stalls the CPU two cycles.
// - Read strobe loads addressed byte at once and stalls four cycles.
// - During a write, reads are blocked and address writes ignored.
// - Write lasts 67 584 calibrated oscillator cycles, about 8.5 ms; the default divider of 3 clocks gives about 8.1 ms.
// - Control bits: read strobe 0, write strobe 1, arm 2, enable 3.
// - A write in progress completes through a system reset.
`timescale 1ns/1ns
module eac_controller
    import eac_pkg::*;
#(
    parameter int USED_ADDR_BITS = ADDR_BITS,
    parameter int WRITE_TICKS    = WRITE_OSC_CYCLES,
    parameter int OSC_DIV        = OSC_DIV_DEFAULT
)
(
    // Clock and resets
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        porReset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // CPU side
    input  wire logic        globalIrqEnable,
    input  wire logic        flashSelfprogBusy,
    output logic             readyIrq,
    output logic             eventIrq,
    output logic             cpuStall,
    output logic             writeBusy
);

    localparam int CNT_W = $clog2(WRITE_TICKS + 1);
    localparam int DIV_W = $clog2(OSC_DIV + 1);
    localparam logic [11:0] ADDR_MASK =
        12'((1 << USED_ADDR_BITS) - 1);

    generate
        if (USED_ADDR_BITS < 1 || USED_ADDR_BITS > ADDR_BITS
            || WRITE_TICKS < 2 || OSC_DIV < 1)
        begin : g_bad_param
            $error("eac_controller parameter out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [11:0]      addr_reg,      addr_next;
    logic [7:0]       data_reg,      data_next;
    logic             rie_reg,       rie_next;
    logic [2:0]       armCnt_reg,    armCnt_next;
    eac_irq_type      stat_reg,      stat_next;
    eac_irq_type      mask_reg,      mask_next;
    logic             readLoad_reg,  readLoad_next;
    logic [2:0]       stallCnt_reg,  stallCnt_next;
    logic             cpuStall_reg,  cpuStall_next;
    logic             readyIrq_reg,  readyIrq_next;
    logic             eventIrq_reg,  eventIrq_next;
    logic [31:0]      prdata_reg,    prdata_next;
    logic             pready_reg,    pready_next;
    logic             pslverr_reg,   pslverr_next;
    // Write engine, spared by system reset
    logic             busy_reg,      busy_next;
    logic [CNT_W-1:0] writeCnt_reg,  writeCnt_next;
    logic [DIV_W-1:0] divCnt_reg,    divCnt_next;

    logic             armBit;
    logic             apbWr;
    logic             apbSetup;
    logic             ctrlWr;
    logic             writeStart;
    logic             readStart;
    logic             oscTick;
    eac_ctrl_type     ctrlView;
    logic [7:0]       memRdData;

    assign armBit  = (armCnt_reg != 3'h0);
    assign apbWr   = psel && penable && pready_reg && pwrite;
    assign apbSetup = psel && !penable;
    assign ctrlWr  = apbWr && (paddr == OFS_CTRL) && pstrb[0];
    assign oscTick = busy_reg && (divCnt_reg == DIV_W'(OSC_DIV - 1));

    // Start needs live arm, idle engine and idle flash
    assign writeStart = ctrlWr && pwdata[1] && armBit
                        && !busy_reg
                        && !flashSelfprogBusy;
    // Reads are refused while a write runs
    assign readStart  = ctrlWr && pwdata[0] && !busy_reg;

    always_comb
    begin
        ctrlView                = '0;
        ctrlView.readyIrqEnable = rie_reg;
        ctrlView.masterWriteArm = armBit;
        ctrlView.writeStrobe    = busy_reg;
        ctrlView.readStrobe     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Array
    eac_nv_mem #(
        .ADDR_W (ADDR_BITS),
        .DATA_W (8)
    ) u_mem (
        .ref_clk (ref_clk),
        .wrEn    (writeStart),
        .wrAddr  (addr_reg & ADDR_MASK),
        .wrData  (data_reg),
        .rdEn    (readStart),
        .rdAddr  (addr_reg & ADDR_MASK),
        .rdData  (memRdData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write engine: oscillator divider and duration count
    always_comb
    begin
        busy_next     = busy_reg;
        writeCnt_next = writeCnt_reg;
        divCnt_next   = divCnt_reg;
        if (writeStart)
        begin
            busy_next     = 1'b1;
            writeCnt_next = CNT_W'(WRITE_TICKS);
            divCnt_next   = '0;
        end
        else if (busy_reg)
        begin
            divCnt_next = oscTick ? '0 : divCnt_reg + 1'b1;
            if (oscTick)
            begin
                writeCnt_next = writeCnt_reg - 1'b1;
                if (writeCnt_reg == CNT_W'(1))
                begin
                    busy_next = 1'b0;
                end
            end
        end
    end

    // Only power-on clears the engine so a running write survives reset
    always_ff @(posedge ref_clk)
    begin
        if (porReset)
        begin
            busy_reg     <= 1'b0;
            writeCnt_reg <= '0;
            divCnt_reg   <= '0;
        end
        else
        begin
            busy_reg     <= busy_next;
            writeCnt_reg <= writeCnt_next;
            divCnt_reg   <= divCnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers, stall, interrupts and APB answer
    always_comb
    begin
        addr_next     = addr_reg;
        data_next     = data_reg;
        rie_next      = rie_reg;
        armCnt_next   = armBit ? armCnt_reg - 3'h1 : 3'h0;
        mask_next     = mask_reg;
        stat_next     = stat_reg;
        readLoad_next = readStart;
        prdata_next   = prdata_reg;
        pslverr_next  = pslverr_reg;
        pready_next   = apbSetup;
        stallCnt_next = (stallCnt_reg != 3'h0) ? stallCnt_reg - 3'h1 : 3'h0;
        if (apbWr && paddr == OFS_ADDR && !busy_reg)
        begin
            if (pstrb[0])
            begin
                addr_next[7:0] = pwdata[7:0];
            end
            if (pstrb[1])
            begin
                addr_next[11:8] = pwdata[11:8];
            end
        end
        if (apbWr && paddr == OFS_DATA && pstrb[0])
        begin
            data_next = pwdata[7:0];
        end
        if (ctrlWr)
        begin
            rie_next    = pwdata[3];
            armCnt_next = pwdata[2] ? 3'(ARM_WINDOW) : 3'h0;
        end
        if (apbWr && paddr == OFS_MASK && pstrb[0])
        begin
            mask_next = eac_irq_type'(pwdata[2:0]);
        end
        // Clear by writing one; a same-cycle event wins
        if (apbWr && paddr == OFS_STAT && pstrb[0])
        begin
            stat_next = stat_reg & ~eac_irq_type'(pwdata[2:0]);
        end
        if (busy_reg && !busy_next)
        begin
            stat_next.writeDone = 1'b1;
        end
        if (readLoad_reg)
        begin
            data_next          = memRdData;
            stat_next.readDone = 1'b1;
        end
        if (ctrlWr && pwdata[1] && !writeStart)
        begin
            stat_next.strobeRefused = 1'b1;
        end

        if (apbSetup)
        begin
            pslverr_next = 1'b0;
            case (paddr)
                OFS_ADDR: prdata_next = {20'h00000, addr_reg};
                OFS_DATA: prdata_next = {24'h000000, data_reg};
                OFS_CTRL: prdata_next = {24'h000000, ctrlView};
                OFS_STAT: prdata_next = {29'h00000000, stat_reg};
                OFS_MASK: prdata_next = {29'h00000000, mask_reg};
                default:
                begin
                    prdata_next  = 32'h00000000;
                    pslverr_next = 1'b1;
                end
            endcase
        end
        // Stall counts from the starting edge
        if (writeStart)
        begin
            stallCnt_next = 3'(WRITE_STALL);
        end
        else if (readStart)
        begin
            stallCnt_next = 3'(READ_STALL);
        end
        cpuStall_next = (stallCnt_next != 3'h0);
        readyIrq_next = rie_next && globalIrqEnable && !busy_next;
        eventIrq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset || porReset)
        begin
            addr_reg     <= ADDR_RESET;
            data_reg     <= DATA_RESET;
            rie_reg      <= RIE_RESET;
            armCnt_reg   <= 3'h0;
            mask_reg     <= eac_irq_type'(MASK_RESET);
            stat_reg     <= '0;
            readLoad_reg <= 1'b0;
            stallCnt_reg <= 3'h0;
            cpuStall_reg <= 1'b0;
            readyIrq_reg <= 1'b0;
            eventIrq_reg <= 1'b0;
            prdata_reg   <= 32'h00000000;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
        end
        else
        begin
            addr_reg     <= addr_next;
            data_reg     <= data_next;
            rie_reg      <= rie_next;
            armCnt_reg   <= armCnt_next;
            mask_reg     <= mask_next;
            stat_reg     <= stat_next;
            readLoad_reg <= readLoad_next;
            stallCnt_reg <= stallCnt_next;
            cpuStall_reg <= cpuStall_next;
            readyIrq_reg <= readyIrq_next;
            eventIrq_reg <= eventIrq_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
        end
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign readyIrq  = readyIrq_reg;
    assign eventIrq  = eventIrq_reg;
    assign cpuStall  = cpuStall_reg;
    assign writeBusy = busy_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset || porReset);

    a_arm_window: assert property (
        $rose(armBit) |-> (armCnt_reg == 3'(ARM_WINDOW)) ##1
            ((armCnt_reg == 3'h3) || ctrlWr) [*1])
        else $error("arm window not four cycles");
    a_arm_expire: assert property (
        (armCnt_reg == 3'h1 && !ctrlWr) |=> !armBit)
        else $error("arm bit did not clear");
    a_start_armed: assert property (
        $rose(busy_reg) |-> $past(armBit) && $past(ctrlWr))
        else $error("write started without arm");
    a_flash_block: assert property (
        $rose(busy_reg) |-> !$past(flashSelfprogBusy))
        else $error("write started during flash busy");
    a_write_stall: assert property (
        $rose(busy_reg) |-> cpuStall_reg [*2] ##1 !cpuStall_reg)
        else $error("write stall not two cycles");
    a_read_stall: assert property (
        (readLoad_reg && !$past(readLoad_reg)) |->
            cpuStall_reg [*4] ##1 !cpuStall_reg)
        else $error("read stall not four cycles");
    a_read_load: assert property (
        readLoad_reg |=> data_reg == $past(memRdData))
        else $error("read byte not loaded");
    // System reset may clear the address under a running write
    a_busy_blocks: assert property (
        busy_reg && $past(busy_reg) && !$past(reset) |->
            !readLoad_reg && $stable(addr_reg))
        else $error("access during write");
    a_write_length: assert property (
        $fell(busy_reg) |-> $past(writeCnt_reg) == CNT_W'(1) && $past(oscTick))
        else $error("write ended early");
    a_count_kept: assert property (
        busy_reg && $past(busy_reg) && !$past(oscTick) |->
            $stable(writeCnt_reg))
        else $error("write count disturbed");
    a_ready_irq: assert property (
        readyIrq_reg == $past(rie_reg && globalIrqEnable && !busy_reg)
            || $past(ctrlWr) || $past(busy_reg) != busy_reg)
        else $error("ready interrupt wrong");
    a_ctrl_zero: assert property (
        pready_reg && psel && !pwrite && paddr == OFS_CTRL |->
            prdata_reg[31:4] == 28'h0000000)
        else $error("reserved bits not zero");
    c_write_done: cover property ($fell(busy_reg));
    c_read: cover property (readLoad_reg);
    c_refused: cover property ($rose(stat_reg.strobeRefused));
    c_event_irq: cover property ($rose(eventIrq_reg));

endmodule : eac_controller

// ### bench/eac_testbench.sv
// Self-checking bench for the EEPROM access controller over APB.
// Assumes the controller answers APB with one access cycle and a short
// write time set through its parameters.
`timescale 1ns/1ns
module testbench;
    import eac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Short write so the run stays brief; ten array address bits alias
    localparam int TICKS   = 8;
    localparam int DIV     = 3;
    localparam int WR_CLKS = TICKS * DIV;
    localparam int LIMIT   = 4000;

    logic        ref_clk;
    logic        reset;
    logic        porReset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        globalIrqEnable;
    logic        flashSelfprogBusy;
    logic        readyIrq;
    logic        eventIrq;
    logic        cpuStall;
    logic        writeBusy;
    logic [31:0] q;
    logic        lastErr;
    int          errors;
    int          n_tests;
    int          cycles;
    int          n;
    time         t0;

    eac_controller #(
        .USED_ADDR_BITS (10),
        .WRITE_TICKS    (TICKS),
        .OSC_DIV        (DIV)
    ) DUT (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .porReset          (porReset),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .pstrb             (pstrb),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .globalIrqEnable   (globalIrqEnable),
        .flashSelfprogBusy (flashSelfprogBusy),
        .readyIrq          (readyIrq),
        .eventIrq          (eventIrq),
        .cpuStall          (cpuStall),
        .writeBusy         (writeBusy)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles > LIMIT)
        begin
            errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd      = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rdchk

    task automatic waitIdle();
        #1;
        while (writeBusy !== 1'b0)
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask : waitIdle

    // Called one step after the launching edge
    task automatic stallLen(output int len);
        len = 0;
        while (cpuStall === 1'b1 && len < 9)
        begin
            len++;
            @(posedge ref_clk);
            #1;
        end
    endtask : stallLen

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {globalIrqEnable, flashSelfprogBusy} = 2'b00;
        pstrb = 4'hF;
        reset = 1'b1;
        porReset = 1'b1;
        errors = 0;
        n_tests = 0;
        cycles = 0;
        repeat (8) @(posedge ref_clk);
        porReset <= 1'b0;
        reset <= 1'b0;
        rdchk(OFS_DATA, 32'h00000000);
        chk(lastErr, 1'b0);
        rdchk(OFS_CTRL, 32'h00000000);
        rdchk(OFS_MASK, 32'h00000000);
        wr(OFS_ADDR, 32'h0000FC05);
        rdchk(OFS_ADDR, 32'h00000C05);
        wr(OFS_CTRL, 32'h000000F8);
        rdchk(OFS_CTRL, 32'h00000008);
        wr(OFS_CTRL, 32'h00000002);
        #1 chk(writeBusy, 1'b0);
        rdchk(OFS_STAT, 32'h00000004);
        wr(OFS_STAT, 32'h00000007);
        rdchk(OFS_STAT, 32'h00000000);
        // Armed write, then everything a running write must shrug off
        wr(OFS_DATA, 32'h000000A5);
        wr(OFS_CTRL, 32'h00000004);
        wr(OFS_CTRL, 32'h00000006);
        t0 = $time;
        #1 chk(writeBusy, 1'b1);
        stallLen(n);
        chk(n, WRITE_STALL);
        apb(1'b0, OFS_CTRL, 32'h0, q);
        chk(q & 32'h2, 32'h00000002);
        wr(OFS_ADDR, 32'h000000AA);
        rdchk(OFS_ADDR, 32'h00000C05);
        wr(OFS_CTRL, 32'h00000004);
        wr(OFS_CTRL, 32'h00000006);
        wr(OFS_DATA, 32'h00000000);
        wr(OFS_CTRL, 32'h00000001);
        waitIdle();
        chk(32'(($time - 1 - t0) / 40), WR_CLKS);
        rdchk(OFS_DATA, 32'h00000000);
        rdchk(OFS_STAT, 32'h00000005);
        wr(OFS_STAT, 32'h00000007);
        // Read through an alias of the written location
        wr(OFS_ADDR, 32'h00000005);
        wr(OFS_CTRL, 32'h00000001);
        #1 stallLen(n);
        chk(n, READ_STALL);
        rdchk(OFS_DATA, 32'h000000A5);
        // Arm expiry
        wr(OFS_CTRL, 32'h00000004);
        apb(1'b0, OFS_CTRL, 32'h0, q);
        chk(q & 32'h4, 32'h00000004);
        repeat (4) @(posedge ref_clk);
        rdchk(OFS_CTRL, 32'h00000000);
        wr(OFS_CTRL, 32'h00000002);
        #1 chk(writeBusy, 1'b0);
        // Flash self-programming blocks the start
        @(posedge ref_clk);
        flashSelfprogBusy <= 1'b1;
        wr(OFS_CTRL, 32'h00000004);
        wr(OFS_CTRL, 32'h00000006);
        #1 chk(writeBusy, 1'b0);
        @(posedge ref_clk);
        flashSelfprogBusy <= 1'b0;
        // Interrupts around a write
        wr(OFS_STAT, 32'h00000007);
        wr(OFS_MASK, 32'h00000001);
        wr(OFS_CTRL, 32'h00000008);
        repeat (2) @(posedge ref_clk);
        #1 chk(readyIrq, 1'b0);
        @(posedge ref_clk);
        globalIrqEnable <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk(readyIrq, 1'b1);
        wr(OFS_CTRL, 32'h0000000C);
        wr(OFS_CTRL, 32'h0000000E);
        repeat (2) @(posedge ref_clk);
        #1 chk(readyIrq, 1'b0);
        chk(eventIrq, 1'b0);
        waitIdle();
        repeat (2) @(posedge ref_clk);
        #1 chk(readyIrq, 1'b1);
        chk(eventIrq, 1'b1);
        wr(OFS_STAT, 32'h00000001);
        repeat (2) @(posedge ref_clk);
        #1 chk(eventIrq, 1'b0);
        // Plain reset in mid-write must not cut the write short
        wr(OFS_ADDR, 32'h00000001);
        wr(OFS_DATA, 32'h0000003C);
        wr(OFS_CTRL, 32'h00000004);
        wr(OFS_CTRL, 32'h00000006);
        @(posedge ref_clk);
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        #1 chk(writeBusy, 1'b1);
        waitIdle();
        wr(OFS_ADDR, 32'h00000001);
        wr(OFS_CTRL, 32'h00000001);
        repeat (4) @(posedge ref_clk);
        rdchk(OFS_DATA, 32'h0000003C);
        // Only the low byte lane enabled: address bits 11..8 kept
        pstrb <= 4'h1;
        wr(OFS_ADDR, 32'h00000F33);
        rdchk(OFS_ADDR, 32'h00000033);
        pstrb <= 4'hF;
        // Unmapped offset
        apb(1'b0, 12'h020, 32'h0, q);
        chk(lastErr, 1'b1);
        chk(q, 32'h00000000);
        conclude();
    end

endmodule : testbench
